// ==== rtl/rsq_pkg.sv ====
// Constants, types and layouts shared by the serial query responder
// What this block does
// RULE1 - Screen replies: STX first, CR LF last
// RULE2 - Display position reply: 10 to 13 characters
// RULE3 - Raw position: sign plus digits, zeros kept
// RULE4 - Error query answered only while error shown
// RULE5 - Error text field is 35 characters
// RULE6 - Software ID reply: 10-character field
// RULE7 - Status bar: eight fields, fixed order
// RULE8 - Status bar field codes, page 4 locked
// RULE9 - Indicators: ten fields, SET eighth, REF ninth
// RULE10 - Indicator code 0 off, 1 on, 2 flashing
// RULE11 - Valid function: send ACK, then execute
// RULE12 - Invalid function: NAK, execute nothing
// RULE13 - Toggle inverts reference evaluation enable
// RULE14 - Print sends measured value like STX request
// RULE15 - Reset acts like power cycle
// RULE16 - Lock: ACK, then ignore local keys
// RULE17 - Lock holds until release or power cycle
// RULE18 - Release: ACK, then enable local keys
// RULE19 - STX on receive returns active-mode values
// RULE20 - Latch within 1 ms, output within 50 ms
// RULE21 - Record plus configured blank lines appended
// RULE22 - Record: sign, 10 chars, leading zeros blank
// RULE23 - XOFF at 100 buffered characters, XON when drained
// RULE24 - Query codes select the six screen replies
// RULE25 - F and S codes select the five functions
package rsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Control and text characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_INCH = 8'h22;
  localparam logic [7:0] CH_FAULT = 8'h3F;
  localparam logic [7:0] CH_PAGE_LOCKED = 8'h34;
  localparam logic [7:0] CH_LETTER_A = 8'h41;
  localparam logic [7:0] CH_LETTER_F = 8'h46;
  localparam logic [7:0] CH_LETTER_S = 8'h53;

  ////////////////////////////////////////////////////////////////////////////
  // Four-digit command codes as ASCII
  localparam logic [31:0] CODE_DISP = 32'h30313030;
  localparam logic [31:0] CODE_RAW = 32'h30323030;
  localparam logic [31:0] CODE_ERR = 32'h30333031;
  localparam logic [31:0] CODE_SWID = 32'h30343030;
  localparam logic [31:0] CODE_BAR = 32'h30383030;
  localparam logic [31:0] CODE_IND = 32'h30393030;
  localparam logic [31:0] CODE_0000 = 32'h30303030;
  localparam logic [31:0] CODE_0001 = 32'h30303031;
  localparam logic [31:0] CODE_0002 = 32'h30303032;

  ////////////////////////////////////////////////////////////////////////////
  // Field sizes
  localparam int TEXT_CHARS = 35;
  localparam logic [5:0] BODY_SINGLE = 6'h01;
  localparam logic [5:0] BODY_RAW = 6'h0A;
  localparam logic [5:0] BODY_ERR = 6'h23;
  localparam logic [5:0] BODY_SWID = 6'h0A;
  localparam logic [5:0] BODY_BAR = 6'h08;
  localparam logic [5:0] BODY_IND = 6'h0A;
  localparam logic [5:0] BODY_MEAS = 6'h0F;
  localparam logic [6:0] EOL_CHARS = 7'h02;
  localparam logic [2:0] CMD_LAST = 3'h5;
  localparam logic [2:0] UNIT_INCH = 3'h1;
  localparam logic [2:0] UNIT_MAX = 3'h4;

  // Software identification, value arbitrary
  localparam logic [79:0] SW_ID_DEFAULT = 80'h30303030303030303030;

  ////////////////////////////////////////////////////////////////////////////
  // Receive command buffer
  localparam int BUF_AW = 7;
  localparam int BUF_DEPTH = 128;
  localparam logic [7:0] BUF_FULL = 8'h80;
  localparam logic [7:0] BUF_LIMIT = 8'h64;

  localparam logic REF_EVAL_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int LATCH_DELAY_NS = 1000000;
  localparam int OUTPUT_START_DELAY_NS = 50000000;
  localparam int REGENERATION_GAP_NS = 0;
  localparam int LATCH_DELAY_CYCLES = LATCH_DELAY_NS / CLOCK_PERIOD_NS;
  localparam int OUTPUT_START_CYCLES = OUTPUT_START_DELAY_NS / CLOCK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    K_NONE, K_ACK, K_NAK, K_XON, K_XOFF, K_DISP, K_RAW, K_ERR, K_SWID, K_BAR, K_IND, K_MEAS
  } rsq_kind_t;

  typedef enum logic [2:0] {
    ACT_NONE, ACT_TOGGLE, ACT_PRINT, ACT_RESET, ACT_LOCK, ACT_RELEASE
  } rsq_act_t;

  typedef enum logic [1:0] {P_FETCH, P_TAKE, P_EXEC} rsq_parse_t;

  typedef struct packed {
    logic [103:0] text;
    logic [5:0] len;
  } rsq_disp_t;

  typedef struct packed {
    logic negative;
    logic [71:0] digits;
  } rsq_raw_t;

  typedef struct packed {
    logic negative;
    logic [79:0] digits;
  } rsq_meas_t;

  typedef struct packed {
    logic mode;
    logic [2:0] axis;
    logic scaling;
    logic comp;
    logic stopwatch;
    logic [2:0] unit;
    logic [1:0] datum;
    logic [1:0] page;
  } rsq_bar_t;

  typedef struct packed {
    logic [1:0] set_code;
    logic [1:0] ref_code;
  } rsq_ind_t;

  typedef struct packed {
    logic stx;
    logic [5:0] body;
    logic crlf;
  } rsq_layout_t;

endpackage

// ==== rtl/rsq_cmd_mem.sv ====
// Receive command buffer memory with registered read
`timescale 1ns/1ns
`default_nettype none
module rsq_cmd_mem
  import rsq_pkg::*;
(
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [BUF_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [BUF_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [BUF_DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ==== rtl/rsq_responder.sv ====
// Serial query responder: command parser, reply formatter and transmitter
`timescale 1ns/1ns
`default_nettype none
module rsq_responder
  import rsq_pkg::*;
#(
  parameter logic [79:0] SOFTWARE_ID = SW_ID_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  output logic RX_READY,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire rsq_disp_t DISPLAY,
  input wire rsq_raw_t RAW_POSITION,
  input wire logic ERROR_SHOWN,
  input wire logic [279:0] ERROR_TEXT,
  input wire rsq_bar_t STATUS_BAR,
  input wire rsq_ind_t INDICATORS,
  input wire rsq_meas_t MEASURED,
  input wire logic [6:0] BLANK_LINES,
  input wire logic LOCAL_KEY_VALID,
  output logic LOCAL_KEY_ACCEPT,
  output logic REF_EVAL_ENABLE,
  output logic KEYPAD_LOCKED,
  output logic UNIT_RESET,
  output logic LATCH_STROBE
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] as_digit(input logic [2:0] v);
    as_digit = CH_ZERO + {5'h00, v};
  endfunction

  function automatic logic [7:0] sign_char(input logic negative);
    sign_char = negative ? CH_MINUS : CH_PLUS;
  endfunction

  // Leading zeros become spaces, except before a point or at the end
  function automatic logic [79:0] blank_leading(input logic [79:0] d);
    logic lead;
    logic [87:0] ext;
    logic [7:0] c;
    logic [7:0] nxt;
    blank_leading = d;
    lead = 1'b1;
    ext = {d, CH_DOT};
    for (int i = 0; i < 10; i++) begin
      c = ext[87-8*i -: 8];
      nxt = ext[79-8*i -: 8];
      if (lead && c == CH_ZERO && nxt != CH_DOT) begin
        blank_leading[79-8*i -: 8] = CH_SPACE;
      end else if (c != CH_SPACE) begin
        lead = 1'b0;
      end
    end
  endfunction

  function automatic rsq_layout_t layout_of(input rsq_kind_t k, input logic [5:0] disp_len);
    layout_of.stx = 1'b1;
    layout_of.crlf = 1'b1;
    layout_of.body = BODY_SINGLE;
    case (k)
      K_DISP: layout_of.body = disp_len;
      K_RAW: layout_of.body = BODY_RAW;
      K_ERR: layout_of.body = BODY_ERR;
      K_SWID: layout_of.body = BODY_SWID;
      K_BAR: layout_of.body = BODY_BAR;
      K_IND: layout_of.body = BODY_IND;
      K_MEAS: begin
        layout_of.stx = 1'b0;
        layout_of.body = BODY_MEAS;
      end
      default: begin
        layout_of.stx = 1'b0;
        layout_of.crlf = 1'b0;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic unit_reset;
  logic rst_all;
  logic [BUF_AW-1:0] wptr;
  logic [BUF_AW-1:0] rptr;
  logic [7:0] count;
  logic [7:0] buf_q;
  logic xoff_sent;
  rsq_parse_t pstate;
  logic in_cmd;
  logic [2:0] cmd_cnt;
  logic [7:0] cmd_letter;
  logic [31:0] cmd_code;
  logic cmd_term;
  logic exec_meas;
  rsq_kind_t kind;
  rsq_layout_t lay;
  logic [279:0] snap;
  logic [6:0] idx;
  logic [6:0] rlen;
  rsq_act_t pend_act;
  logic [7:0] tx_data;
  logic tx_valid;
  logic print_due;
  logic ref_en;
  logic locked;
  logic latch_strobe;

  assign rst_all = RESET || unit_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and flow control

  wire push = RX_VALID && RX_READY;
  wire pop = pstate == P_TAKE;
  wire xoff_due = count >= BUF_LIMIT && !xoff_sent; // RULE23
  wire xon_due = xoff_sent && count == 8'h00; // RULE23
  wire flow_due = xoff_due || xon_due;

  assign RX_READY = count != BUF_FULL;

  rsq_cmd_mem u_mem (
    .clock(CLOCK),
    .wr_en(push),
    .wr_addr(wptr),
    .wr_data(RX_DATA),
    .rd_addr(rptr),
    .rd_data(buf_q)
  );

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      wptr <= '0;
      rptr <= '0;
      count <= 8'h00;
    end else begin
      wptr <= wptr + BUF_AW'(push);
      rptr <= rptr + BUF_AW'(pop);
      count <= count + 8'(push) - 8'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command parser

  wire idle = kind == K_NONE;
  wire flow_go = idle && flow_due;
  wire meas_go = idle && !flow_due && print_due;
  wire cmd_go = idle && !flow_due && !print_due && pstate == P_EXEC;

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      pstate <= P_FETCH;
      in_cmd <= 1'b0;
      cmd_cnt <= 3'h0;
      cmd_letter <= 8'h00;
      cmd_code <= 32'h00000000;
      cmd_term <= 1'b0;
      exec_meas <= 1'b0;
    end else begin
      case (pstate)
        P_FETCH: begin
          if (count != 8'h00) begin
            pstate <= P_TAKE;
          end
        end
        P_TAKE: begin
          pstate <= P_FETCH;
          if (buf_q == CH_STX) begin
            exec_meas <= 1'b1; // RULE19
            in_cmd <= 1'b0;
            pstate <= P_EXEC;
          end else if (buf_q == CH_ESC) begin
            in_cmd <= 1'b1; // RULE24
            cmd_cnt <= 3'h0;
          end else if (in_cmd) begin
            cmd_cnt <= cmd_cnt + 3'h1;
            if (cmd_cnt == 3'h0) begin
              cmd_letter <= buf_q;
            end else if (cmd_cnt == CMD_LAST) begin
              cmd_term <= buf_q == CH_CR;
              exec_meas <= 1'b0;
              in_cmd <= 1'b0;
              pstate <= P_EXEC;
            end else begin
              cmd_code <= {cmd_code[23:0], buf_q};
            end
          end
        end
        P_EXEC: begin
          if (cmd_go) begin
            pstate <= P_FETCH;
          end
        end
        default: pstate <= P_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire is_query = cmd_term && cmd_letter == CH_LETTER_A;
  wire is_func = cmd_term && cmd_letter == CH_LETTER_F;
  wire is_spec = cmd_term && cmd_letter == CH_LETTER_S;

  wire rsq_act_t dec_act =
    (is_func && cmd_code == CODE_0000) ? ACT_TOGGLE : // RULE25
    (is_func && cmd_code == CODE_0002) ? ACT_PRINT :
    (is_spec && cmd_code == CODE_0000) ? ACT_RESET :
    (is_spec && cmd_code == CODE_0001) ? ACT_LOCK :
    (is_spec && cmd_code == CODE_0002) ? ACT_RELEASE : ACT_NONE;

  wire rsq_kind_t dec_kind =
    exec_meas ? K_MEAS : // RULE19
    (is_query && cmd_code == CODE_DISP) ? K_DISP : // RULE24
    (is_query && cmd_code == CODE_RAW) ? K_RAW :
    (is_query && cmd_code == CODE_ERR && ERROR_SHOWN) ? K_ERR : // RULE4
    (is_query && cmd_code == CODE_SWID) ? K_SWID :
    (is_query && cmd_code == CODE_BAR) ? K_BAR :
    (is_query && cmd_code == CODE_IND) ? K_IND :
    (dec_act != ACT_NONE) ? K_ACK : K_NAK; // RULE12

  ////////////////////////////////////////////////////////////////////////////
  // Reply text selection

  wire [7:0] unit_char =
    (STATUS_BAR.unit == UNIT_INCH) ? CH_INCH :
    (STATUS_BAR.unit > UNIT_MAX) ? CH_FAULT : CH_SPACE;

  wire [7:0] page_char = locked ? CH_PAGE_LOCKED : as_digit({1'b0, STATUS_BAR.page}); // RULE8

  wire [63:0] bar_text = {
    as_digit({2'b00, STATUS_BAR.mode}), as_digit(STATUS_BAR.axis),
    as_digit({2'b00, STATUS_BAR.scaling}), as_digit({2'b00, STATUS_BAR.comp}),
    as_digit({2'b00, STATUS_BAR.stopwatch}), as_digit(STATUS_BAR.unit),
    as_digit({1'b0, STATUS_BAR.datum}), page_char}; // RULE7

  wire [79:0] ind_text = {
    {7{CH_ZERO}}, as_digit({1'b0, INDICATORS.set_code}), // RULE9
    as_digit({1'b0, INDICATORS.ref_code}), CH_ZERO}; // RULE10

  wire [119:0] meas_text = {
    sign_char(MEASURED.negative), blank_leading(MEASURED.digits), // RULE22
    CH_SPACE, unit_char, CH_SPACE, CH_SPACE};

  wire rsq_kind_t start_kind = flow_go ? (xoff_due ? K_XOFF : K_XON) : meas_go ? K_MEAS : dec_kind;
  wire start = flow_go || meas_go || cmd_go;

  wire [279:0] start_text =
    (start_kind == K_DISP) ? {DISPLAY.text, {22{CH_SPACE}}} : // RULE2
    (start_kind == K_RAW) ? {sign_char(RAW_POSITION.negative), RAW_POSITION.digits,
      {25{CH_SPACE}}} : // RULE3
    (start_kind == K_ERR) ? ERROR_TEXT : // RULE5
    (start_kind == K_SWID) ? {SOFTWARE_ID, {25{CH_SPACE}}} : // RULE6
    (start_kind == K_BAR) ? {bar_text, {27{CH_SPACE}}} :
    (start_kind == K_IND) ? {ind_text, {25{CH_SPACE}}} :
    (start_kind == K_MEAS) ? {meas_text, {20{CH_SPACE}}} :
    (start_kind == K_ACK) ? {CH_ACK, {34{CH_SPACE}}} : // RULE11
    (start_kind == K_XOFF) ? {CH_XOFF, {34{CH_SPACE}}} :
    (start_kind == K_XON) ? {CH_XON, {34{CH_SPACE}}} : {CH_NAK, {34{CH_SPACE}}};

  wire rsq_layout_t start_lay = layout_of(start_kind, DISPLAY.len);
  wire [6:0] extra_lf = (start_kind == K_MEAS) ? BLANK_LINES : 7'h00; // RULE21
  wire [6:0] start_len = 7'(start_lay.stx) + {1'b0, start_lay.body} +
    (start_lay.crlf ? EOL_CHARS + extra_lf : 7'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  wire [6:0] stx_len = 7'(lay.stx);
  wire [6:0] q = idx - stx_len;
  wire [6:0] body_len = {1'b0, lay.body};
  wire [8:0] text_bit = 9'h117 - {q[5:0], 3'b000};
  wire [7:0] cur_byte =
    (idx < stx_len) ? CH_STX : // RULE1
    (q < body_len) ? snap[text_bit -: 8] :
    (q == body_len) ? CH_CR : CH_LF; // RULE1
  wire tx_free = !tx_valid || TX_READY;
  wire send = !idle && tx_free;
  wire last = idx == rlen - 7'h01;
  wire act_fire = send && last && kind == K_ACK; // RULE11

  assign TX_DATA = tx_data;
  assign TX_VALID = tx_valid;

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      kind <= K_NONE;
      lay <= '0;
      snap <= '0;
      idx <= 7'h00;
      rlen <= 7'h00;
      pend_act <= ACT_NONE;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      xoff_sent <= 1'b0;
    end else begin
      if (start) begin
        kind <= start_kind;
        lay <= start_lay;
        snap <= start_text;
        idx <= 7'h00;
        rlen <= start_len;
        pend_act <= cmd_go ? dec_act : ACT_NONE; // RULE12
      end else if (send) begin
        tx_data <= cur_byte;
        idx <= idx + 7'h01;
        if (last) begin
          kind <= K_NONE;
        end
      end
      if (send) begin
        tx_valid <= 1'b1;
      end else if (TX_READY) begin
        tx_valid <= 1'b0;
      end
      if (flow_go) begin
        xoff_sent <= xoff_due; // RULE23
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function execution, as the acknowledge is offered; reset once it is taken

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      unit_reset <= 1'b0;
    end else begin
      unit_reset <= idle && pend_act == ACT_RESET && tx_valid && TX_READY; // RULE15
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      ref_en <= REF_EVAL_RESET; // RULE15
      locked <= 1'b0; // RULE17
      print_due <= 1'b0;
      latch_strobe <= 1'b0;
    end else begin
      latch_strobe <= start && start_kind == K_MEAS; // RULE20
      if (act_fire && pend_act == ACT_TOGGLE) begin
        ref_en <= !ref_en; // RULE13
      end
      if (act_fire && pend_act == ACT_LOCK) begin
        locked <= 1'b1; // RULE16
      end else if (act_fire && pend_act == ACT_RELEASE) begin
        locked <= 1'b0; // RULE18
      end
      if (act_fire && pend_act == ACT_PRINT) begin
        print_due <= 1'b1; // RULE14
      end else if (meas_go) begin
        print_due <= 1'b0;
      end
    end
  end

  assign LOCAL_KEY_ACCEPT = LOCAL_KEY_VALID && !locked; // RULE16
  assign REF_EVAL_ENABLE = ref_en;
  assign KEYPAD_LOCKED = locked;
  assign UNIT_RESET = unit_reset;
  assign LATCH_STROBE = latch_strobe;

endmodule
`default_nettype wire

// ==== bench/rsq_monitor.sv ====
// Concurrent checks on the serial query responder ports
`timescale 1ns/1ns
`default_nettype none
module rsq_monitor
  import rsq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic LOCAL_KEY_ACCEPT,
  input wire logic REF_EVAL_ENABLE,
  input wire logic KEYPAD_LOCKED,
  input wire logic UNIT_RESET,
  input wire logic LATCH_STROBE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  logic ack_now;
  assign ack_now = TX_VALID && TX_DATA == CH_ACK;
  ////////////////////////////////////////////////////////////////////////////
  // ACK offered now or one cycle ago
  sequence s_ack;
    ack_now || $past(ack_now);
  endsequence
  sequence s_stx_idle;
    RX_VALID && RX_READY && RX_DATA == CH_STX && !TX_VALID;
  endsequence
  property p_ref_ack;
    $changed(REF_EVAL_ENABLE) && !$past(UNIT_RESET) |-> s_ack;
  endproperty
  property p_lock_ack;
    $rose(KEYPAD_LOCKED) |-> s_ack;
  endproperty
  property p_free_ack;
    $fell(KEYPAD_LOCKED) && !$past(UNIT_RESET) |-> s_ack;
  endproperty
  property p_keys_off;
    KEYPAD_LOCKED |-> !LOCAL_KEY_ACCEPT;
  endproperty
  property p_unit_reset;
    UNIT_RESET |=> !UNIT_RESET && REF_EVAL_ENABLE && !KEYPAD_LOCKED;
  endproperty
  property p_nak_idle;
    TX_VALID && TX_DATA == CH_NAK |=> $stable(REF_EVAL_ENABLE) && $stable(KEYPAD_LOCKED);
  endproperty
  property p_tx_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
  endproperty
  property p_stx_latch;
    s_stx_idle |-> ##[1:1000] LATCH_STROBE;
  endproperty
  property p_latch_out;
    LATCH_STROBE |-> ##[0:1000] TX_VALID;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_ref_ack: assert property (p_ref_ack)
    else $error("ref enable changed without ack");
  a_lock_ack: assert property (p_lock_ack)
    else $error("keypad locked without ack");
  a_free_ack: assert property (p_free_ack)
    else $error("keypad released without ack");
  a_keys_off: assert property (p_keys_off)
    else $error("local key accepted while locked");
  a_unit_reset: assert property (p_unit_reset)
    else $error("unit reset left state behind");
  a_nak_idle: assert property (p_nak_idle)
    else $error("state changed on nak");
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte dropped while stalled");
  a_stx_latch: assert property (p_stx_latch)
    else $error("no latch after stx");
  a_latch_out: assert property (p_latch_out)
    else $error("no output after latch");
endmodule

bind rsq_responder rsq_monitor i_rsq_monitor (
  .CLOCK(CLOCK), .RESET(RESET), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
  .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .LOCAL_KEY_ACCEPT(LOCAL_KEY_ACCEPT), .REF_EVAL_ENABLE(REF_EVAL_ENABLE),
  .KEYPAD_LOCKED(KEYPAD_LOCKED), .UNIT_RESET(UNIT_RESET), .LATCH_STROBE(LATCH_STROBE)
);
`default_nettype wire

// ==== bench/rsq_host_model.sv ====
// Host side serial partner: sends bytes, collects replies
`timescale 1ns/1ns
`default_nettype none
module rsq_host_model
  import rsq_pkg::*;
(
  input wire logic clock,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [1:0] mode
);
  logic [7:0] got[$];
  logic paused = 1'b0;
  initial begin
    rx_data = 8'hFF;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // Ready: 0 prompt, 1 every other cycle, 2 stalled
  always @(negedge clock) begin
    tx_ready <= (mode == 2'h0) || (mode == 2'h1 && !tx_ready);
  end
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_data == CH_XOFF) paused <= 1'b1;
      if (tx_data == CH_XON) paused <= 1'b0;
    end
  end
  // Byte held until taken; none while paused
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    while (paused && n < 20000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    rx_data = b;
    rx_valid = 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (!rx_ready && n < 40000);
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask
endmodule
`default_nettype wire

// ==== bench/rsq_testbench.sv ====
// Self-checking testbench for the serial query responder
`timescale 1ns/1ns
`default_nettype none
module testbench
  import rsq_pkg::*;
;
  // Value arbitrary
  localparam logic [79:0] SW_ID = "4210987650";
  logic clock, reset, rx_valid, rx_ready, tx_valid, tx_ready, error_shown, key_valid;
  logic key_accept, ref_enable, locked, unit_reset, latch_strobe;
  logic [7:0] rx_data, tx_data;
  logic [279:0] error_text;
  logic [6:0] blank_lines;
  logic [1:0] mode;
  rsq_disp_t display;
  rsq_raw_t raw;
  rsq_bar_t bar;
  rsq_ind_t ind;
  rsq_meas_t meas;
  int failures = 0, n_compared = 0, resets = 0, strobes = 0;
  logic [7:0] exp[$];

  rsq_responder #(.SOFTWARE_ID(SW_ID)) i_rsq_responder (
    .CLOCK(clock), .RESET(reset), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .DISPLAY(display),
    .RAW_POSITION(raw), .ERROR_SHOWN(error_shown), .ERROR_TEXT(error_text), .STATUS_BAR(bar),
    .INDICATORS(ind), .MEASURED(meas), .BLANK_LINES(blank_lines), .LOCAL_KEY_VALID(key_valid),
    .LOCAL_KEY_ACCEPT(key_accept), .REF_EVAL_ENABLE(ref_enable), .KEYPAD_LOCKED(locked),
    .UNIT_RESET(unit_reset), .LATCH_STROBE(latch_strobe));
  rsq_host_model i_rsq_host_model (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .mode(mode));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (unit_reset) resets++;
    if (latch_strobe) strobes++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic add(input logic [279:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      exp.push_back(v[i*8 +: 8]);
  endtask
  task automatic frame(input logic [279:0] v, input int n);
    exp.push_back(CH_STX);
    add(v, n);
    exp.push_back(CH_CR);
    exp.push_back(CH_LF);
  endtask
  task automatic one(input logic [7:0] b);
    exp.push_back(b);
  endtask
  task automatic cmd(input logic [7:0] letter, input logic [31:0] code, input logic [7:0] t);
    i_rsq_host_model.send(CH_ESC);
    i_rsq_host_model.send(letter);
    for (int i = 3; i >= 0; i--)
      i_rsq_host_model.send(code[i*8 +: 8]);
    i_rsq_host_model.send(t);
  endtask
  task automatic reply();
    int n;
    n = 0;
    while (i_rsq_host_model.got.size() < exp.size() && n < 20000) begin
      @(negedge clock);
      n++;
    end
    repeat (40) @(negedge clock);
    chk(16'(i_rsq_host_model.got.size()), 16'(exp.size()));
    foreach (exp[i])
      if (i < i_rsq_host_model.got.size())
        chk(16'(i_rsq_host_model.got[i]), 16'(exp[i]));
    i_rsq_host_model.got.delete();
    exp.delete();
  endtask
  task automatic record();
    add("-   12.3400 \"  ", 15);
    add({CH_CR, CH_LF, CH_LF, CH_LF}, 4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_queries();
    display = '{text: "-1234.567890Q", len: 6'h0C};
    cmd(CH_LETTER_A, CODE_DISP, CH_CR);
    frame(display.text[103:8], 12);
    reply();
    raw = '{1'b0, "000012345"};
    cmd(CH_LETTER_A, CODE_RAW, CH_CR);
    frame("+000012345", 10);
    reply();
    cmd(CH_LETTER_A, CODE_ERR, CH_CR);
    one(CH_NAK);
    reply();
    error_shown = 1'b1;
    cmd(CH_LETTER_A, CODE_ERR, CH_CR);
    frame(error_text, 35);
    reply();
    cmd(CH_LETTER_A, CODE_SWID, CH_CR);
    frame(SW_ID, 10);
    reply();
    for (int u = 0; u < 5; u++) begin
      bar = '{1'b1, 3'h0, 1'b1, 1'b0, 1'b1, 3'(u), 2'h2, 2'h3};
      cmd(CH_LETTER_A, CODE_BAR, CH_CR);
      frame({"10101", 8'(8'h30 + u), "23"}, 8);
      reply();
    end
    bar = '{1'b0, 3'h0, 1'b0, 1'b1, 1'b0, 3'h1, 2'h1, 2'h1};
    cmd(CH_LETTER_A, CODE_BAR, CH_CR);
    frame("00010111", 8);
    reply();
    cmd(CH_LETTER_A, CODE_IND, CH_CR);
    frame("0000000210", 10);
    reply();
    $display("done: screen queries");
  endtask
  task automatic t_functions();
    logic [7:0] lt[4] = '{CH_LETTER_F, CH_LETTER_S, CH_LETTER_A, CH_LETTER_A};
    logic [31:0] cd[4] = '{CODE_0001, 32'h30303033, CODE_0000, CODE_BAR};
    logic [7:0] tm[4] = '{CH_CR, CH_CR, CH_CR, 8'h58};
    for (int i = 0; i < 2; i++) begin
      cmd(CH_LETTER_F, CODE_0000, CH_CR);
      one(CH_ACK);
      reply();
      chk(16'(ref_enable), 16'(i));
    end
    for (int i = 0; i < 4; i++) begin
      cmd(lt[i], cd[i], tm[i]);
      one(CH_NAK);
      reply();
      chk(16'(ref_enable), 16'h0001);
    end
    $display("done: functions");
  endtask
  task automatic t_keypad();
    cmd(CH_LETTER_S, CODE_0001, CH_CR);
    one(CH_ACK);
    reply();
    chk(16'(locked), 16'h0001);
    chk(16'(key_accept), 16'h0000);
    cmd(CH_LETTER_A, CODE_BAR, CH_CR);
    frame("00010114", 8);
    reply();
    cmd(CH_LETTER_S, CODE_0002, CH_CR);
    one(CH_ACK);
    reply();
    chk(16'(key_accept), 16'h0001);
    cmd(CH_LETTER_S, CODE_0001, CH_CR);
    cmd(CH_LETTER_F, CODE_0000, CH_CR);
    cmd(CH_LETTER_S, CODE_0000, CH_CR);
    add({CH_ACK, CH_ACK, CH_ACK}, 3);
    reply();
    chk(16'(resets), 16'h0001);
    chk(16'({ref_enable, locked}), 16'h0002);
    $display("done: keypad and reset");
  endtask
  task automatic t_measure();
    meas = '{1'b1, "00012.3400"};
    i_rsq_host_model.send(CH_STX);
    record();
    reply();
    mode = 2'h1;
    cmd(CH_LETTER_F, CODE_0002, CH_CR);
    one(CH_ACK);
    record();
    reply();
    chk(16'(strobes), 16'h0002);
    $display("done: measured values");
  endtask
  task automatic t_flow();
    mode = 2'h2;
    repeat (2) cmd(CH_LETTER_A, CODE_IND, CH_CR);
    repeat (20) @(negedge clock);
    repeat (100) i_rsq_host_model.send(8'h5A);
    chk(16'(rx_ready), 16'h0001);
    mode = 2'h0;
    frame("0000000210", 10);
    one(CH_XOFF);
    frame("0000000210", 10);
    one(CH_XON);
    reply();
    $display("done: flow control");
  endtask
  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    mode = 2'h0;
    key_valid = 1'b1;
    error_shown = 1'b0;
    error_text = "0123456789ABCDEFGHIJKLMNOPQRSTUVWXY";
    blank_lines = 7'h02;
    display = '0;
    raw = '0;
    bar = '0;
    ind = '{2'h2, 2'h1};
    meas = '0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    t_queries();
    t_functions();
    t_keypad();
    t_measure();
    t_flow();
    summarize();
  end
endmodule
`default_nettype wire
